// File: dv/pll_vco_band_control_test.sv
`timescale 1ns/100ps
`default_nettype none
module pll_vco_band_control_test;
   logic       REF_CLK, RESET_N, REG_WR_EN, REG_RD_EN;   // clock, reset, strobes
   logic [7:0] REG_ADDR, REG_WDATA, REG_RDATA;          // register port
   logic       VCO_IN_RANGE, PLL_LOCK_DETECT;           // analog stand-ins
   logic       PLL_ENABLE, PLL_POWER_DOWN, SAMPLE_CLOCK_DIRECT, CROSS_POINT_EN;
   logic [5:0] VCO_BAND;                                // applied band
   logic [2:0] LOOP_BANDWIDTH;                          // loop field
   logic [4:0] CHARGE_PUMP_CURRENT;                     // pump field
   logic [7:0] DIVIDER_CONTROL;                         // divider byte
   logic [7:0] exp_q[$];                                // expected read data
   logic [5:0] lo, hi;                                  // in-range window
   logic       win_on;                                  // window enabled
   logic [7:0] d;                                       // random byte
   int         fail_count, compares;                    // tallies
   pvb_top dut (.REF_CLK(REF_CLK), .RESET_N(RESET_N), .REG_WR_EN(REG_WR_EN),
      .REG_RD_EN(REG_RD_EN), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
      .REG_RDATA(REG_RDATA), .VCO_IN_RANGE(VCO_IN_RANGE),
      .PLL_LOCK_DETECT(PLL_LOCK_DETECT), .PLL_ENABLE(PLL_ENABLE),
      .PLL_POWER_DOWN(PLL_POWER_DOWN), .SAMPLE_CLOCK_DIRECT(SAMPLE_CLOCK_DIRECT),
      .VCO_BAND(VCO_BAND), .LOOP_BANDWIDTH(LOOP_BANDWIDTH),
      .CHARGE_PUMP_CURRENT(CHARGE_PUMP_CURRENT), .CROSS_POINT_EN(CROSS_POINT_EN),
      .DIVIDER_CONTROL(DIVIDER_CONTROL));
   // 200 MHz clock
   always #2.5 REF_CLK = ~REF_CLK;
   // comparator model, one cycle late; bands dwell long
   always @(posedge REF_CLK) begin
      VCO_IN_RANGE <= win_on && (VCO_BAND >= lo) && (VCO_BAND <= hi);
   end
   // shared compare, counts and reports
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         fail_count++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // read data shows one cycle after the strobe edge
   always @(posedge REF_CLK) begin
      if (REG_RD_EN === 1'b1) begin
         #1;
         if (exp_q.size() == 0) chk(REG_RDATA, 8'hXX);
         else chk(REG_RDATA, exp_q.pop_front());
      end
   end
   // hang guard, well past the longest searches
   initial begin
      #400000;
      fail_count++;
      final_report();
   end
   task automatic idle(input int n);
      repeat (n) @(posedge REF_CLK);
      #1;
   endtask
   // one write, strobe drops at the taking edge
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge REF_CLK);
      REG_WR_EN <= 1'b1;
      REG_ADDR  <= a;
      REG_WDATA <= v;
      @(posedge REF_CLK);
      REG_WR_EN <= 1'b0;
      #1;
   endtask
   // one read; the monitor checks the note pushed here
   task automatic rd(input logic [7:0] a, input logic [7:0] v);
      @(posedge REF_CLK);
      exp_q.push_back(v);
      REG_RD_EN <= 1'b1;
      REG_ADDR  <= a;
      @(posedge REF_CLK);
      REG_RD_EN <= 1'b0;
      idle(1);
   endtask
   task automatic final_report();
      $display("comparisons %0d mismatches %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   initial begin
      REF_CLK = 0; RESET_N = 0; REG_WR_EN = 0; REG_RD_EN = 0; REG_ADDR = 8'h00;
      REG_WDATA = 8'h00; VCO_IN_RANGE = 0; PLL_LOCK_DETECT = 0; win_on = 0;
      lo = 6'h00; hi = 6'h00; fail_count = 0; compares = 0;
      void'($urandom(52));
      repeat (2) @(posedge REF_CLK);
      RESET_N <= 1'b1;
      // reset values and idle outputs
      rd(8'h12, 8'h00); rd(8'h14, 8'hE7); rd(8'h15, 8'h00); rd(8'h16, 8'h00);
      rd(8'h13, 8'h00);
      chk({7'h00, PLL_POWER_DOWN}, 8'h01);
      chk({7'h00, SAMPLE_CLOCK_DIRECT}, 8'h01);
      chk({5'h00, LOOP_BANDWIDTH}, 8'h07);
      chk({3'h0, CHARGE_PUMP_CURRENT}, 8'h07);
      $display("test reset done");
      // random loop and divider bytes, unmapped write ignored
      for (int i = 0; i < 6; i++) begin
         d = 8'($urandom);
         wr(8'h14, d);
         chk({5'h00, LOOP_BANDWIDTH}, {5'h00, d[7:5]});
         chk({3'h0, CHARGE_PUMP_CURRENT}, {3'h0, d[4:0]});
         rd(8'h14, d);
         wr(8'h15, ~d);
         chk({7'h00, CROSS_POINT_EN}, {7'h00, ~d[4]});
         chk(DIVIDER_CONTROL, ~d);
         wr(8'h13, d);
         rd(8'h15, ~d);
      end
      $display("test fields done");
      // manual order: band and mode together, then enable, every code
      for (int b = 0; b < 64; b++) begin
         wr(8'h12, 8'(b) | 8'h40);
         wr(8'h12, 8'(b) | 8'hC0);
         idle(1);
         chk({2'h0, VCO_BAND}, 8'(b));
         chk({6'h00, PLL_ENABLE, PLL_POWER_DOWN}, 8'h02);
      end
      $display("test manual done");
      // automatic order, then abort mid-search
      lo = 6'($urandom_range(0, 40));
      hi = lo + 6'($urandom_range(0, 20));
      win_on = 1;
      wr(8'h15, 8'hC1); wr(8'h14, 8'hE7); wr(8'h12, 8'h40);
      wr(8'h12, 8'hC0); wr(8'h12, 8'h80);
      rd(8'h16, 8'h20);
      idle(300);
      wr(8'h12, 8'hC5);
      idle(1);
      chk({2'h0, VCO_BAND}, 8'h05);
      rd(8'h16, 8'h00);
      $display("test abort done");
      // full search with lock detect high
      @(posedge REF_CLK);
      PLL_LOCK_DETECT <= 1'b1;
      wr(8'h12, 8'hC0); wr(8'h12, 8'h80);
      idle(13000);
      chk({2'h0, VCO_BAND}, {2'h0, 6'((7'(lo) + 7'(hi)) >> 1)});
      rd(8'h16, 8'h00);
      idle(1100);
      rd(8'h16, 8'h80);
      @(posedge REF_CLK);
      PLL_LOCK_DETECT <= 1'b0;
      idle(3);
      rd(8'h16, 8'h00);
      $display("test search done");
      // no band in range: default band and fail flag
      win_on = 0;
      wr(8'h12, 8'hC0); wr(8'h12, 8'h80);
      idle(13000);
      chk({2'h0, VCO_BAND}, 8'h20);
      rd(8'h16, 8'h40);
      $display("test nohit done");
      // disable: multiplier off, direct clock back
      wr(8'h12, 8'h00);
      chk({5'h00, PLL_ENABLE, PLL_POWER_DOWN, SAMPLE_CLOCK_DIRECT}, 8'h03);
      rd(8'h12, 8'h00);
      $display("test disable done");
      idle(2);
      final_report();
   end
endmodule // pll_vco_band_control_test
`default_nettype wire

// File: src/pvb_band_search.sv
`timescale 1ns/100ps
`default_nettype none
module pvb_band_search (
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic       start,      // trigger pulse
   input  wire logic       abort,      // pll disabled or mode left auto
   input  wire logic       in_range,   // vco tuning within window
   output logic            busy,
   output logic            done,
   output logic            found_q,
   output logic [5:0]      try_band,
   output logic [5:0]      band_sel_q
);
   // one-hot search states
   typedef enum logic [2:0] {
      SR_IDLE = 3'b001,
      SR_RUN  = 3'b010,
      SR_PICK = 3'b100
   } pvb_sr_type;

   pvb_sr_type         state_q, state_d;
   logic [5:0]         code_q, code_d;     // band under test
   logic [5:0]         lo_q, lo_d;         // first in-range band
   logic [5:0]         hi_q, hi_d;         // last in-range band
   logic [5:0]         sel_d;
   logic               found_d;
   logic [9:0]         cnt_q, cnt_d;       // settle per band

   // next state: sweep every band, then choose
   always_comb begin
      state_d = state_q;
      code_d  = code_q;
      lo_d    = lo_q;
      hi_d    = hi_q;
      sel_d   = band_sel_q;
      found_d = found_q;
      cnt_d   = cnt_q;
      case (state_q)
         SR_IDLE: begin
            if (start) begin
               state_d = SR_RUN;
               code_d  = 6'h00;
               cnt_d   = 10'h000;
               found_d = 1'b0;
            end
         end
         SR_RUN: begin
            if (pvb_pkg::cnt_end(cnt_q, pvb_pkg::BAND_SETTLE_CYC)) begin
               // sample only after the vco has settled on this band
               if (in_range) begin
                  if (!found_q) begin
                     lo_d = code_q;
                  end
                  hi_d    = code_q;
                  found_d = 1'b1;
               end
               cnt_d = 10'h000;
               if (code_q == pvb_pkg::BAND_LAST) begin
                  state_d = SR_PICK;
               end else begin
                  code_d = code_q + 6'h01;
               end
            end else begin
               cnt_d = cnt_q + 10'h001;
            end
         end
         SR_PICK: begin
            // no band in range: fall back to mid band
            sel_d   = found_q ? pvb_pkg::band_mid(lo_q, hi_q) : pvb_pkg::BAND_DEFAULT;
            state_d = SR_IDLE;
         end
         default: state_d = SR_IDLE;
      endcase
      if (abort) begin
         state_d = SR_IDLE;
         sel_d   = band_sel_q; // a cut sweep keeps the old choice
      end
   end

   // registers only
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q    <= SR_IDLE;
         code_q     <= 6'h00;
         lo_q       <= 6'h00;
         hi_q       <= 6'h00;
         band_sel_q <= pvb_pkg::BAND_DEFAULT;
         found_q    <= 1'b0;
         cnt_q      <= 10'h000;
      end else begin
         state_q    <= state_d;
         code_q     <= code_d;
         lo_q       <= lo_d;
         hi_q       <= hi_d;
         band_sel_q <= sel_d;
         found_q    <= found_d;
         cnt_q      <= cnt_d;
      end
   end

   assign busy     = (state_q != SR_IDLE);
   assign done     = (state_q == SR_PICK) && !abort;
   assign try_band = code_q;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   a_search_starts: assert property (state_q == SR_IDLE && start && !abort |=>
      busy && code_q == 6'h00)
      else $error("search did not start at band zero");
   a_pick_inside: assert property (done && found_q |=>
      band_sel_q >= $past(lo_q) && band_sel_q <= $past(hi_q))
      else $error("chosen band outside in-range run");
   a_band_step: assert property (state_q == SR_RUN && !abort
      && !pvb_pkg::cnt_end(cnt_q, pvb_pkg::BAND_SETTLE_CYC) |=> $stable(code_q))
      else $error("band advanced before settling");
   c_found: cover property (done && found_q);
   c_not_found: cover property (done && !found_q);
endmodule // pvb_band_search
`default_nettype wire

// File: src/pvb_pkg.sv
// How it works
// - loop field: bandwidth[7:5], pump[4:0], reset E7
// - cross point enable bit at divider bit 4
// - six-bit band code picks one of 64
// - write C0 then 80 triggers auto search
// - search picks band and applies it itself
// - manual mode drives band from control field
// - control bit 7 enables the multiplier
// - enable low powers down, selects direct clock
// - lock status bit 7 reports lock
`default_nettype none
package pvb_pkg;
   // register offsets on the control port
   localparam logic [7:0] ADDR_PLL_CONTROL   = 8'h12;
   localparam logic [7:0] ADDR_LOOP_SETTINGS = 8'h14;
   localparam logic [7:0] ADDR_DIVIDER_CTRL  = 8'h15;
   localparam logic [7:0] ADDR_LOCK_STATUS   = 8'h16;
   // reset values
   localparam logic [7:0] RST_PLL_CONTROL    = 8'h00;
   localparam logic [7:0] RST_LOOP_SETTINGS  = 8'hE7;
   localparam logic [7:0] RST_DIVIDER_CTRL   = 8'h00;
   // trigger pair for the automatic search, top two control bits
   localparam logic [1:0] CTRL_TOP_MANUAL_ON = 2'h3;
   localparam logic [1:0] CTRL_TOP_AUTO_ON   = 2'h2;
   // field positions
   localparam int CTRL_EN_BIT   = 7;
   localparam int CTRL_MODE_BIT = 6;
   localparam int BAND_W        = 6;
   localparam int LOOP_BW_LSB   = 5;
   localparam int LOOP_BW_W     = 3;
   localparam int CP_W          = 5;
   localparam int DIV_XPT_BIT   = 4;
   localparam int STAT_LOCK_BIT = 7;
   localparam int STAT_FAIL_BIT = 6;
   localparam int STAT_BUSY_BIT = 5;
   // band space
   localparam logic [5:0] BAND_LAST    = 6'h3F;
   localparam logic [5:0] BAND_DEFAULT = 6'h20;
   // timing
   localparam int CLK_MHZ         = 200;
   localparam int BAND_SETTLE_NS  = 1000;
   localparam int LOOP_SETTLE_NS  = 5000;
   localparam int BAND_SETTLE_CYC = (BAND_SETTLE_NS * CLK_MHZ + 999) / 1000;
   localparam int LOOP_SETTLE_CYC = (LOOP_SETTLE_NS * CLK_MHZ + 999) / 1000;
   localparam int CNT_W           = 10;
   // middle of the in-range run keeps margin both ways over temperature
   function automatic logic [5:0] band_mid(input logic [5:0] lo, input logic [5:0] hi);
      logic [6:0] sum;
      sum = {1'b0, lo} + {1'b0, hi};
      return sum[6:1];
   endfunction
   // settle counter end test, used by search and lock timing
   function automatic logic cnt_end(input logic [9:0] cnt, input int cyc);
      return cnt == 10'(cyc - 1);
   endfunction
endpackage
`default_nettype wire

// File: src/pvb_top.sv
`timescale 1ns/100ps
`default_nettype none
module pvb_top (
   input  wire logic       REF_CLK,
   input  wire logic       RESET_N,
   input  wire logic       REG_WR_EN,            // write strobe
   input  wire logic       REG_RD_EN,            // read strobe
   input  wire logic [7:0] REG_ADDR,
   input  wire logic [7:0] REG_WDATA,
   output logic      [7:0] REG_RDATA,            // registered, one cycle after read
   input  wire logic       VCO_IN_RANGE,         // band comparator from the analog vco
   input  wire logic       PLL_LOCK_DETECT,      // raw analog lock detect
   output logic            PLL_ENABLE,
   output logic            PLL_POWER_DOWN,
   output logic            SAMPLE_CLOCK_DIRECT,  // 1: sample_clock_input pins feed the core
   output logic      [5:0] VCO_BAND,
   output logic      [2:0] LOOP_BANDWIDTH,
   output logic      [4:0] CHARGE_PUMP_CURRENT,
   output logic            CROSS_POINT_EN,
   output logic      [7:0] DIVIDER_CONTROL
);
   logic [7:0]         ctrl_q, ctrl_d;       // pll control
   logic [7:0]         loop_q, loop_d;       // loop settings
   logic [7:0]         div_q, div_d;         // divider control
   logic [7:0]         rdata_d;
   logic [5:0]         band_q, band_d;       // band driven to the vco
   logic [9:0]         settle_q, settle_d;   // loop settle timer
   logic               settled_q, settled_d;
   logic               lock_q, lock_d;
   logic               wr_ctrl, wr_loop, wr_div;
   logic               start, abort, busy, done, found;
   logic [5:0]         try_band, band_sel;
   logic               en, manual;

   // address decode
   assign wr_ctrl = REG_WR_EN && REG_ADDR == pvb_pkg::ADDR_PLL_CONTROL;
   assign wr_loop = REG_WR_EN && REG_ADDR == pvb_pkg::ADDR_LOOP_SETTINGS;
   assign wr_div  = REG_WR_EN && REG_ADDR == pvb_pkg::ADDR_DIVIDER_CTRL;
   assign en      = ctrl_q[pvb_pkg::CTRL_EN_BIT];
   assign manual  = ctrl_q[pvb_pkg::CTRL_MODE_BIT];

   // trigger: enabled manual value followed by enabled auto value
   assign start = wr_ctrl && ctrl_q[7:6] == pvb_pkg::CTRL_TOP_MANUAL_ON
                  && REG_WDATA[7:6] == pvb_pkg::CTRL_TOP_AUTO_ON;
   // leaving auto or disabling stops a search in flight; a control write
   // is judged by the value being written, so the trigger write itself
   // never reads as an abort while the old manual value still stands
   assign abort = wr_ctrl
                  ? (!REG_WDATA[pvb_pkg::CTRL_EN_BIT] || REG_WDATA[pvb_pkg::CTRL_MODE_BIT])
                  : (!en || manual);

   pvb_band_search u_search (
      .clk        (REF_CLK),
      .rst_n      (RESET_N),
      .start      (start),
      .abort      (abort),
      .in_range   (VCO_IN_RANGE),
      .busy       (busy),
      .done       (done),
      .found_q    (found),
      .try_band   (try_band),
      .band_sel_q (band_sel)
   );

   // register file next values; the status offset is read only
   always_comb begin
      ctrl_d  = ctrl_q;
      loop_d  = loop_q;
      div_d   = div_q;
      rdata_d = REG_RDATA;
      if (wr_ctrl) begin
         ctrl_d = REG_WDATA;
      end
      if (wr_loop) begin
         loop_d = REG_WDATA;
      end
      if (wr_div) begin
         div_d = REG_WDATA;
      end
      if (REG_RD_EN) begin
         case (REG_ADDR)
            pvb_pkg::ADDR_PLL_CONTROL:   rdata_d = ctrl_q;
            pvb_pkg::ADDR_LOOP_SETTINGS: rdata_d = loop_q;
            pvb_pkg::ADDR_DIVIDER_CTRL:  rdata_d = div_q;
            pvb_pkg::ADDR_LOCK_STATUS: begin
               rdata_d = 8'h00;
               rdata_d[pvb_pkg::STAT_LOCK_BIT] = lock_q;
               // no-band flag whenever enabled auto mode sits idle with nothing found, never mid-sweep
               rdata_d[pvb_pkg::STAT_FAIL_BIT] = !found && !manual && en && !busy;
               rdata_d[pvb_pkg::STAT_BUSY_BIT] = busy;
            end
            // unmapped offsets read as zero
            default: rdata_d = 8'h00;
         endcase
      end
   end

   // register file and read data
   always_ff @(posedge REF_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         ctrl_q    <= pvb_pkg::RST_PLL_CONTROL;
         loop_q    <= pvb_pkg::RST_LOOP_SETTINGS;
         div_q     <= pvb_pkg::RST_DIVIDER_CTRL;
         REG_RDATA <= 8'h00;
      end else begin
         ctrl_q    <= ctrl_d;
         loop_q    <= loop_d;
         div_q     <= div_d;
         REG_RDATA <= rdata_d;
      end
   end

   // band and lock: band source by mode, lock waits out the settle time
   always_comb begin
      if (manual) begin
         band_d = ctrl_q[pvb_pkg::BAND_W-1:0];
      end else if (busy) begin
         band_d = try_band;
      end else begin
         band_d = band_sel;
      end
      settle_d  = settle_q;
      settled_d = settled_q;
      // any band change or search restarts the settle wait
      // a new band moves the vco off frequency, so the loop needs the
      // full settle time again before the raw detect is believed
      if (!en || busy || band_d != band_q) begin
         settle_d  = 10'h000;
         settled_d = 1'b0;
      end else if (!settled_q) begin
         if (pvb_pkg::cnt_end(settle_q, pvb_pkg::LOOP_SETTLE_CYC)) begin
            settled_d = 1'b1;
         end else begin
            settle_d = settle_q + 10'h001;
         end
      end
      // raw detect is not trusted while the band is moving
      lock_d = en && settled_q && !busy && PLL_LOCK_DETECT;
   end

   // band, settle and lock registers
   always_ff @(posedge REF_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         band_q    <= 6'h00;
         settle_q  <= 10'h000;
         settled_q <= 1'b0;
         lock_q    <= 1'b0;
      end else begin
         band_q    <= band_d;
         settle_q  <= settle_d;
         settled_q <= settled_d;
         lock_q    <= lock_d;
      end
   end

   // outputs straight from flops
   assign PLL_ENABLE          = en;
   assign PLL_POWER_DOWN      = !en;
   assign SAMPLE_CLOCK_DIRECT = !en;
   assign VCO_BAND            = band_q;
   assign LOOP_BANDWIDTH      = loop_q[pvb_pkg::LOOP_BW_LSB +: pvb_pkg::LOOP_BW_W];
   assign CHARGE_PUMP_CURRENT = loop_q[pvb_pkg::CP_W-1:0];
   assign CROSS_POINT_EN      = div_q[pvb_pkg::DIV_XPT_BIT];
   assign DIVIDER_CONTROL     = div_q;

   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (!RESET_N);

   // register writes land in the outputs one cycle later
   a_loop_fields: assert property (wr_loop |=>
      LOOP_BANDWIDTH == $past(REG_WDATA[7:5]) && CHARGE_PUMP_CURRENT == $past(REG_WDATA[4:0]))
      else $error("loop fields not taken from write");
   a_loop_read: assert property (REG_RD_EN && REG_ADDR == pvb_pkg::ADDR_LOOP_SETTINGS |=>
      REG_RDATA == $past(loop_q))
      else $error("loop settings readback wrong");
   a_cross_point: assert property (wr_div |=> CROSS_POINT_EN == $past(REG_WDATA[4]))
      else $error("cross point bit not taken from write");
   a_div_read: assert property (REG_RD_EN && REG_ADDR == pvb_pkg::ADDR_DIVIDER_CTRL |=>
      REG_RDATA == $past(div_q))
      else $error("divider readback wrong");
   // control register: enable, trigger, manual band
   a_enable_write: assert property (wr_ctrl |=> PLL_ENABLE == $past(REG_WDATA[7]))
      else $error("enable bit not taken from write");
   a_ctrl_read: assert property (REG_RD_EN && REG_ADDR == pvb_pkg::ADDR_PLL_CONTROL |=>
      REG_RDATA == $past(ctrl_q))
      else $error("control readback wrong");
   a_auto_trigger: assert property (wr_ctrl && REG_WDATA == 8'h80 && ctrl_q == 8'hC0 |=>
      busy)
      else $error("C0 then 80 did not start search");
   a_abort_write: assert property (wr_ctrl && (!REG_WDATA[pvb_pkg::CTRL_EN_BIT]
      || REG_WDATA[pvb_pkg::CTRL_MODE_BIT]) |=> !busy)
      else $error("search kept running after leaving auto");
   a_manual_band: assert property (manual && $stable(ctrl_q) |=>
      VCO_BAND == $past(ctrl_q[5:0]))
      else $error("manual band not driven from control field");
   // search: the vco follows the band under test, then the chosen band
   a_band_follow: assert property (busy && !manual |=> VCO_BAND == $past(try_band))
      else $error("band under test not driven to vco");
   a_search_apply: assert property (done |=> ##1 VCO_BAND == $past(band_sel, 1))
      else $error("chosen band not applied");
   a_status_busy: assert property (REG_RD_EN && REG_ADDR == pvb_pkg::ADDR_LOCK_STATUS |=>
      REG_RDATA[pvb_pkg::STAT_BUSY_BIT] == $past(busy))
      else $error("busy bit misreported");
   // bypass and lock
   a_direct_clock: assert property (!PLL_ENABLE |-> SAMPLE_CLOCK_DIRECT && PLL_POWER_DOWN)
      else $error("disabled pll not bypassed");
   a_bypass_write: assert property (wr_ctrl && !REG_WDATA[pvb_pkg::CTRL_EN_BIT] |=>
      SAMPLE_CLOCK_DIRECT && PLL_POWER_DOWN)
      else $error("disable write did not select direct clock");
   a_lock_read: assert property (REG_RD_EN && REG_ADDR == pvb_pkg::ADDR_LOCK_STATUS |=>
      REG_RDATA[pvb_pkg::STAT_LOCK_BIT] == $past(lock_q))
      else $error("lock bit misreported");
   a_lock_hold: assert property (busy |=> !lock_q)
      else $error("lock shown during search");
   a_lock_off: assert property (!PLL_ENABLE |=> !lock_q)
      else $error("lock shown with pll disabled");
   a_lock_settle: assert property ($rose(lock_q) |->
      $past(settled_q) && $past(band_q) == band_q)
      else $error("lock before loop settled");
   c_auto_lock: cover property (!manual && $rose(settled_q) ##1 $rose(lock_q));
   c_manual_lock: cover property (manual && $rose(lock_q));
   c_bypass: cover property ($fell(PLL_ENABLE));
endmodule // pvb_top
`default_nettype wire
